// File: common/i2c_ts_pkg.sv
// Summary of operation
// - Write address byte is 0x84 or 0x86.
// - Read address byte is 0x85 or 0x87.
// - Sample address and write bits on SCL rise.
// - Acknowledge matching address low through ninth clock.
// - Master starts with SDA falling while SCL high.
// - Idle bus rests high, nobody driving low.
// - Read bits MSB first, changed after SCL falls.
// - Device may stretch SCL; master waits release.
// - Acknowledge every written byte on ninth clock.
// - Status line is open-drain wired-AND, rests high.
// - Pull status low when fresh data ready.
// - Host holds status low; buffer stays frozen.
// - Refresh buffer only while status line high.
// - Unread at periodic update: release, refresh, reassert.
// - Status handshake applies only to reads.
// - Seven-bit slave only, repeated start, stretching.
// - Address-select pin gives address bit zero.
package i2c_ts_pkg;

  localparam logic [5:0]  ADDR_PREFIX      = 6'h21;
  localparam logic [3:0]  BYTE_BITS        = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT      = 4'h7;
  localparam int          MCLK_MHZ         = 200;
  localparam int          UPDATE_PERIOD_US = 5000;
  localparam int          UPDATE_CYCLES    = UPDATE_PERIOD_US * MCLK_MHZ;
  localparam int          BUF_DEPTH        = 32;
  localparam logic        PIN_IDLE         = 1'h1;

  localparam logic [1:0]  EV_FETCH_FIRST   = 2'h0;
  localparam logic [1:0]  EV_FETCH_NEXT    = 2'h1;
  localparam logic [1:0]  EV_WRITE         = 2'h2;
  localparam logic [1:0]  EV_WRITE_FIRST   = 2'h3;

endpackage

// File: rtl/sync2_level.sv
`timescale 1ns/1ps
`default_nettype none
module sync2_level #(
  parameter logic RST_VAL = 1'h1
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: rtl/word_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module word_handshake #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_nrst,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  input  wire logic         dst_clk,
  input  wire logic         dst_nrst,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);

  logic         req_q;
  logic [W-1:0] hold_q;
  logic         ack_s;
  logic         req_s;
  logic         req_p_q;

  // The held word only changes while no request is in flight, so the far side reads it settled.
  always_ff @(posedge src_clk) begin
    if (!src_nrst) begin
      req_q  <= 1'h0;
      hold_q <= '0;
    end else if (src_valid && !src_busy) begin
      req_q  <= ~req_q;
      hold_q <= src_data;
    end
  end

  assign src_busy = req_q != ack_s;

  sync2_level #(.RST_VAL(1'h0)) u_req_sync (
    .clk  (dst_clk),
    .nrst (dst_nrst),
    .d    (req_q),
    .q    (req_s)
  );

  sync2_level #(.RST_VAL(1'h0)) u_ack_sync (
    .clk  (src_clk),
    .nrst (src_nrst),
    .d    (req_p_q),
    .q    (ack_s)
  );

  always_ff @(posedge dst_clk) begin
    if (!dst_nrst) begin
      req_p_q   <= 1'h0;
      dst_valid <= 1'h0;
      dst_data  <= '0;
    end else begin
      req_p_q   <= req_s;
      dst_valid <= req_s != req_p_q;
      if (req_s != req_p_q) begin
        dst_data <= hold_q;
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/i2c_ts_slave.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_ts_slave #(
  parameter int          BUF_DEPTH     = i2c_ts_pkg::BUF_DEPTH,
  parameter int unsigned UPDATE_CYCLES = i2c_ts_pkg::UPDATE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       bus_clk,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       ts_in,
  output logic            ts_out,
  output logic            ts_oe,
  input  wire logic       addr_select_pin,
  input  wire logic       fill_valid,
  input  wire logic [7:0] fill_data,
  input  wire logic       fill_last,
  output logic            fill_ready,
  output logic            cmd_valid,
  output logic [7:0]      cmd_data,
  output logic            cmd_first,
  output logic            host_reading
);

  localparam int IW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  generate
    if (BUF_DEPTH < 2 || UPDATE_CYCLES < 2) begin : g_bad_param
      $error("BUF_DEPTH and UPDATE_CYCLES must both be at least 2");
    end
  endgenerate

  typedef enum logic [3:0] {
    B_IDLE, B_ADDR, B_AACK, B_RLOAD, B_RDATA, B_RACK, B_WDATA, B_WACK, B_IGNORE
  } bus_state_t;

  typedef enum logic [1:0] {T_FILL, T_AVAIL, T_READ} ts_state_t;

  function automatic logic addr_match(input logic [6:0] a, input logic sel);
    return a == {i2c_ts_pkg::ADDR_PREFIX, sel};
  endfunction

  // ---------------------------------------------------------------- link side, bus_clk

  logic       bus_nrst;
  logic       scl_s;
  logic       sda_s;
  logic       as_s;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;

  sync2_level #(.RST_VAL(1'h0)) u_rst_sync (
    .clk  (bus_clk),
    .nrst (1'h1),
    .d    (nrst),
    .q    (bus_nrst)
  );

  sync2_level #(.RST_VAL(i2c_ts_pkg::PIN_IDLE)) u_scl_sync (
    .clk  (bus_clk),
    .nrst (bus_nrst),
    .d    (scl_in),
    .q    (scl_s)
  );

  sync2_level #(.RST_VAL(i2c_ts_pkg::PIN_IDLE)) u_sda_sync (
    .clk  (bus_clk),
    .nrst (bus_nrst),
    .d    (sda_in),
    .q    (sda_s)
  );

  sync2_level #(.RST_VAL(1'h0)) u_as_sync (
    .clk  (bus_clk),
    .nrst (bus_nrst),
    .d    (addr_select_pin),
    .q    (as_s)
  );

  always_ff @(posedge bus_clk) begin
    if (!bus_nrst) begin
      scl_p_q <= i2c_ts_pkg::PIN_IDLE;
      sda_p_q <= i2c_ts_pkg::PIN_IDLE;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign rise    = scl_s && !scl_p_q;
  assign fall    = !scl_s && scl_p_q;
  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c  = scl_s && scl_p_q && !sda_p_q && sda_s;

  bus_state_t bst_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic       rw_q;
  logic       wfirst_q;
  logic       mack_q;
  logic       loaded_q;
  logic       pend_q;
  logic [1:0] pend_kind_q;
  logic [7:0] pend_data_q;
  logic       sda_drv_q;
  logic       scl_drv_q;
  logic       stretch_d;
  logic       ev_busy;
  logic       ev_fire;
  logic       rd_valid;
  logic [7:0] rd_data;

  assign ev_fire = pend_q && !ev_busy;

  always_ff @(posedge bus_clk) begin
    if (!bus_nrst) begin
      bst_q       <= B_IDLE;
      cnt_q       <= 4'h0;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      rw_q        <= 1'h0;
      wfirst_q    <= 1'h0;
      mack_q      <= 1'h0;
      loaded_q    <= 1'h0;
      pend_q      <= 1'h0;
      pend_kind_q <= i2c_ts_pkg::EV_FETCH_FIRST;
      pend_data_q <= 8'h00;
      sda_drv_q   <= 1'h0;
    end else begin
      if (ev_fire) begin
        pend_q <= 1'h0;
      end
      if (rd_valid) begin
        tx_q     <= rd_data;
        loaded_q <= 1'h1;
      end
      if (stop_c) begin
        bst_q     <= B_IDLE;
        sda_drv_q <= 1'h0;
        loaded_q  <= 1'h0;
      end else if (start_c) begin
        // A repeated start lands here from any state.
        bst_q     <= B_ADDR;
        cnt_q     <= 4'h0;
        sda_drv_q <= 1'h0;
        loaded_q  <= 1'h0;
      end else begin
        case (bst_q)
          B_ADDR: begin
            if (rise) begin
              rx_q  <= {rx_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == i2c_ts_pkg::BYTE_BITS) begin
              if (addr_match(rx_q[7:1], as_s)) begin
                sda_drv_q <= 1'h1;
                rw_q      <= rx_q[0];
                bst_q     <= B_AACK;
                if (rx_q[0]) begin
                  pend_q      <= 1'h1;
                  pend_kind_q <= i2c_ts_pkg::EV_FETCH_FIRST;
                  pend_data_q <= 8'h00;
                end
              end else begin
                bst_q <= B_IGNORE;
              end
            end
          end
          B_AACK: begin
            if (fall) begin
              sda_drv_q <= 1'h0;
              cnt_q     <= 4'h0;
              wfirst_q  <= 1'h1;
              bst_q     <= rw_q ? B_RLOAD : B_WDATA;
            end
          end
          B_RLOAD: begin
            if (loaded_q) begin
              sda_drv_q <= !tx_q[7];
              cnt_q     <= 4'h0;
              bst_q     <= B_RDATA;
            end
          end
          B_RDATA: begin
            if (fall) begin
              if (cnt_q == i2c_ts_pkg::TX_LAST_BIT) begin
                sda_drv_q <= 1'h0;
                loaded_q  <= 1'h0;
                bst_q     <= B_RACK;
              end else begin
                sda_drv_q <= !tx_q[6];
                tx_q      <= {tx_q[6:0], 1'h0};
                cnt_q     <= cnt_q + 4'h1;
              end
            end
          end
          B_RACK: begin
            if (rise) begin
              mack_q <= !sda_s;
            end else if (fall) begin
              if (mack_q) begin
                pend_q      <= 1'h1;
                pend_kind_q <= i2c_ts_pkg::EV_FETCH_NEXT;
                pend_data_q <= 8'h00;
                bst_q       <= B_RLOAD;
              end else begin
                bst_q <= B_IGNORE;
              end
            end
          end
          B_WDATA: begin
            if (rise) begin
              rx_q  <= {rx_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == i2c_ts_pkg::BYTE_BITS) begin
              sda_drv_q   <= 1'h1;
              bst_q       <= B_WACK;
              pend_q      <= 1'h1;
              pend_kind_q <= wfirst_q ? i2c_ts_pkg::EV_WRITE_FIRST : i2c_ts_pkg::EV_WRITE;
              pend_data_q <= rx_q;
              wfirst_q    <= 1'h0;
            end
          end
          B_WACK: begin
            if (fall) begin
              sda_drv_q <= 1'h0;
              cnt_q     <= 4'h0;
              bst_q     <= B_WDATA;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // SCL is only ever pulled while it is already low, so stretching never forges an edge.
  // The hold lasts one cycle past the load, so a fresh bit is set up before SCL can rise.
  assign stretch_d = (pend_q || bst_q == B_RLOAD) && (scl_drv_q || !scl_s);

  always_ff @(posedge bus_clk) begin
    if (!bus_nrst) begin
      scl_drv_q <= 1'h0;
    end else begin
      scl_drv_q <= stretch_d;
    end
  end

  assign scl_out = 1'h0;
  assign scl_oe  = scl_drv_q;
  assign sda_out = 1'h0;
  assign sda_oe  = sda_drv_q;

  // ---------------------------------------------------------------- core side, mclk

  logic        ev_valid;
  logic [9:0]  ev_word;
  logic        ts_s;
  logic        rsp_valid_q;
  logic [7:0]  rsp_data_q;

  word_handshake #(.W(10)) u_ev_cdc (
    .src_clk   (bus_clk),
    .src_nrst  (bus_nrst),
    .src_valid (ev_fire),
    .src_data  ({pend_kind_q, pend_data_q}),
    .src_busy  (ev_busy),
    .dst_clk   (mclk),
    .dst_nrst  (nrst),
    .dst_valid (ev_valid),
    .dst_data  (ev_word)
  );

  word_handshake #(.W(8)) u_rsp_cdc (
    .src_clk   (mclk),
    .src_nrst  (nrst),
    .src_valid (rsp_valid_q),
    .src_data  (rsp_data_q),
    .src_busy  (),
    .dst_clk   (bus_clk),
    .dst_nrst  (bus_nrst),
    .dst_valid (rd_valid),
    .dst_data  (rd_data)
  );

  sync2_level #(.RST_VAL(i2c_ts_pkg::PIN_IDLE)) u_ts_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (ts_in),
    .q    (ts_s)
  );

  ts_state_t   tst_q;
  logic        ts_drv_q;
  logic [31:0] upd_cnt_q;
  logic        tick;
  logic        fill_fire;
  logic [IW-1:0] wr_idx_q;
  logic [IW-1:0] rd_idx_q;
  logic [7:0]  buf_q [BUF_DEPTH];

  assign tick       = upd_cnt_q == 32'(UPDATE_CYCLES - 1);
  assign fill_ready = tst_q == T_FILL && ts_s;
  assign fill_fire  = fill_valid && fill_ready;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      upd_cnt_q <= 32'h0;
    end else begin
      upd_cnt_q <= tick ? 32'h0 : upd_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (fill_fire) begin
      buf_q[wr_idx_q] <= fill_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wr_idx_q <= '0;
    end else if (fill_fire) begin
      if (fill_last) begin
        wr_idx_q <= '0;
      end else if (wr_idx_q != IW'(BUF_DEPTH - 1)) begin
        wr_idx_q <= wr_idx_q + IW'(1);
      end
    end
  end

  // Writes from the host never touch the status line.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tst_q    <= T_FILL;
      ts_drv_q <= 1'h0;
    end else begin
      case (tst_q)
        T_FILL: begin
          if (fill_fire && fill_last) begin
            tst_q    <= T_AVAIL;
            ts_drv_q <= 1'h1;
          end
        end
        T_AVAIL: begin
          if (ev_valid && ev_word[9:8] == i2c_ts_pkg::EV_FETCH_FIRST) begin
            tst_q    <= T_READ;
            ts_drv_q <= 1'h0;
          end else if (tick && fill_valid) begin
            tst_q    <= T_FILL;
            ts_drv_q <= 1'h0;
          end
        end
        default: begin
          // The line reads high only once the host lets go; only then may the buffer change.
          if (ts_s) begin
            tst_q <= T_FILL;
          end
        end
      endcase
    end
  end

  assign ts_out       = 1'h0;
  assign ts_oe        = ts_drv_q;
  assign host_reading = tst_q == T_READ;

  // Reads past the end of the buffer repeat the byte held in its last entry, buf_q[BUF_DEPTH-1].
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_idx_q    <= '0;
      rsp_valid_q <= 1'h0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= 1'h0;
      if (ev_valid && ev_word[9:8] == i2c_ts_pkg::EV_FETCH_FIRST) begin
        rsp_valid_q <= 1'h1;
        rsp_data_q  <= buf_q[0];
        rd_idx_q    <= IW'(1);
      end else if (ev_valid && ev_word[9:8] == i2c_ts_pkg::EV_FETCH_NEXT) begin
        rsp_valid_q <= 1'h1;
        rsp_data_q  <= buf_q[rd_idx_q];
        if (rd_idx_q != IW'(BUF_DEPTH - 1)) begin
          rd_idx_q <= rd_idx_q + IW'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cmd_valid <= 1'h0;
      cmd_data  <= 8'h00;
      cmd_first <= 1'h0;
    end else begin
      cmd_valid <= ev_valid && ev_word[9];
      if (ev_valid && ev_word[9]) begin
        cmd_data  <= ev_word[7:0];
        cmd_first <= ev_word[8];
      end
    end
  end

  // ---------------------------------------------------------------- checks

  sequence s_addr_done_match;
    fall && bst_q == B_ADDR && cnt_q == i2c_ts_pkg::BYTE_BITS && !start_c && !stop_c
      && addr_match(rx_q[7:1], as_s);
  endsequence

  sequence s_addr_done_miss;
    fall && bst_q == B_ADDR && cnt_q == i2c_ts_pkg::BYTE_BITS && !start_c && !stop_c
      && !addr_match(rx_q[7:1], as_s);
  endsequence

  property p_addr_ack;
    @(posedge bus_clk) disable iff (!bus_nrst)
      s_addr_done_match |=> sda_oe && bst_q == B_AACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address match not acknowledged");

  property p_addr_miss;
    @(posedge bus_clk) disable iff (!bus_nrst)
      s_addr_done_miss |=> !sda_oe [*2];
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("SDA driven after address miss");

  property p_sample_rise;
    @(posedge bus_clk) disable iff (!bus_nrst)
      (rise && bst_q == B_WDATA && !start_c && !stop_c) |=> rx_q[0] == $past(sda_s);
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("data bit not sampled on rise");

  property p_write_ack;
    @(posedge bus_clk) disable iff (!bus_nrst)
      (fall && bst_q == B_WDATA && cnt_q == i2c_ts_pkg::BYTE_BITS && !start_c && !stop_c)
        |=> sda_oe && pend_q;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");

  property p_read_stable;
    @(posedge bus_clk) disable iff (!bus_nrst)
      (bst_q == B_RDATA && !fall && !start_c && !stop_c) |=> $stable(sda_oe);
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("read bit moved off SCL fall");

  property p_stop_release;
    @(posedge bus_clk) disable iff (!bus_nrst)
      stop_c |=> !sda_oe ##1 !scl_oe;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("bus not released after stop");

  property p_refresh_gate;
    @(posedge mclk) disable iff (!nrst)
      (!ts_s || ts_drv_q) |-> !fill_ready;
  endproperty
  a_refresh_gate: assert property (p_refresh_gate) else $error("buffer open while line low");

  property p_fresh_assert;
    @(posedge mclk) disable iff (!nrst)
      (fill_fire && fill_last) |=> ts_oe && tst_q == T_AVAIL;
  endproperty
  a_fresh_assert: assert property (p_fresh_assert) else $error("fresh data not announced");

  property p_periodic_release;
    @(posedge mclk) disable iff (!nrst)
      (tst_q == T_AVAIL && tick && fill_valid && !ev_valid) |=> !ts_oe && tst_q == T_FILL;
  endproperty
  a_periodic_release: assert property (p_periodic_release) else $error("no release at update");

  property p_read_freeze;
    @(posedge mclk) disable iff (!nrst)
      (tst_q == T_READ && !ts_s) |=> $stable(wr_idx_q);
  endproperty
  a_read_freeze: assert property (p_read_freeze) else $error("buffer changed during read");

endmodule
`default_nettype wire

// File: tb/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic  bus_clk,
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  ts,
  output logic       scl_low,
  output logic       sda_low,
  output logic       ts_low,
  output logic       rd_done,
  output logic       stuck,
  output logic [7:0] rd_data
);
  localparam int Q = 6;
  localparam int LIMIT = 20000;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    ts_low  = 1'b0;
    rd_done = 1'b0;
    stuck   = 1'b0;
    rd_data = 8'h00;
  end

  task automatic gap();
    repeat (Q) @(posedge bus_clk);
  endtask

  // The device may hold the clock low, so every high phase waits for the real level.
  task automatic clk_high();
    int n;
    n = 0;
    scl_low <= 1'b0;
    @(posedge bus_clk);
    while (scl !== 1'b1 && n < LIMIT) begin
      @(posedge bus_clk);
      n++;
    end
    if (n >= LIMIT) stuck <= 1'b1;
    gap();
  endtask

  task automatic bit_cycle(input logic v, output logic s);
    sda_low <= ~v;
    gap();
    clk_high();
    s = sda;
    scl_low <= 1'b1;
    gap();
  endtask

  task automatic start();
    sda_low <= 1'b1;
    gap();
    scl_low <= 1'b1;
    gap();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    gap();
    clk_high();
    sda_low <= 1'b0;
    gap();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
    bit_cycle(1'b1, ack);
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(~more, s);
    rd_data = b;
    rd_done <= 1'b1;
    @(posedge bus_clk);
    rd_done <= 1'b0;
  endtask

  task automatic host_read(input logic [6:0] addr, input int n, output logic ack);
    int k;
    logic [7:0] b;
    k = 0;
    while (ts !== 1'b0 && k < LIMIT) begin
      @(posedge bus_clk);
      k++;
    end
    if (k >= LIMIT) stuck <= 1'b1;
    ts_low <= 1'b1;
    start();
    send_byte({addr, 1'b1}, ack);
    if (ack === 1'b0) begin
      for (int i = 0; i < n; i++) recv_byte(i < n - 1, b);
    end
    stop();
    ts_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/i2c_slave_with_transfer_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_with_transfer_status_bench;
  localparam int LIMIT = 20000;
  logic       mclk, nrst, bus_clk, addr_select_pin;
  logic       fill_valid, fill_last, fill_ready;
  logic [7:0] fill_data, cmd_data, m_rd_data, lfsr8, b;
  logic       scl_out, scl_oe, sda_out, sda_oe, ts_out, ts_oe;
  logic       cmd_valid, cmd_first, host_reading, ack;
  logic       m_scl_low, m_sda_low, m_ts_low, m_rd_done, m_stuck;
  logic       scl_w, sda_w, ts_w;
  logic [8:0] exp_cmd[$];
  logic [8:0] exp_rd[$];
  int         bad_count, checked, drops, drops0, k;

  assign scl_w = ~(scl_oe | m_scl_low);
  assign sda_w = ~(sda_oe | m_sda_low);
  assign ts_w  = ~(ts_oe | m_ts_low);

  i2c_ts_slave #(.BUF_DEPTH(8), .UPDATE_CYCLES(200)) dut (
    .mclk(mclk), .nrst(nrst), .bus_clk(bus_clk),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .ts_in(ts_w), .ts_out(ts_out), .ts_oe(ts_oe),
    .addr_select_pin(addr_select_pin),
    .fill_valid(fill_valid), .fill_data(fill_data), .fill_last(fill_last),
    .fill_ready(fill_ready), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_first(cmd_first), .host_reading(host_reading));

  i2c_host_model m (
    .bus_clk(bus_clk), .scl(scl_w), .sda(sda_w), .ts(ts_w),
    .scl_low(m_scl_low), .sda_low(m_sda_low), .ts_low(m_ts_low),
    .rd_done(m_rd_done), .stuck(m_stuck), .rd_data(m_rd_data));

  always #2.5 mclk = ~mclk;
  // The odd offset keeps the link clock edges away from the core clock edges.
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #15 bus_clk = ~bus_clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string name, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic give_up(input int n);
    if (n >= LIMIT) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // Each byte is offered at once and held until fill_ready; the line is then checked released by everyone.
  task automatic fill_frame(input int n, input logic keep);
    int w;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      fill_valid = 1'b1;
      fill_data  = lfsr8;
      fill_last  = (i == n - 1);
      w = 0;
      while (fill_ready !== 1'b1 && w < LIMIT) begin
        @(negedge mclk);
        w++;
      end
      give_up(w);
      chk("line at refresh", 9'h1, {8'h00, ts_w});
      if (keep) exp_rd.push_back({1'b0, lfsr8});
      lfsr8 = lfsr_next(lfsr8);
      @(posedge mclk);
    end
    @(negedge mclk);
    fill_valid = 1'b0;
    fill_last  = 1'b0;
    chk("ts_oe after frame", 9'h1, {8'h00, ts_oe});
  endtask

  always @(posedge mclk) if ($fell(ts_oe)) drops <= drops + 1;
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1) begin
      chk("cmd", exp_cmd.size() ? exp_cmd.pop_front() : 9'h1ff, {cmd_first, cmd_data});
    end
  end
  always @(posedge m_rd_done) begin
    chk("read", exp_rd.size() ? exp_rd.pop_front() : 9'h1ff, {1'b0, m_rd_data});
  end
  always @(posedge m_stuck) begin
    bad_count++;
    end_of_test();
  end

  initial begin
    mclk = 1'b0; nrst = 1'b0; addr_select_pin = 1'b0; lfsr8 = 8'h5b;
    fill_valid = 1'b0; fill_last = 1'b0; fill_data = 8'h00;
    bad_count = 0; checked = 0; drops = 0;
    // Five core cycles; the link side takes it on the bus clock edge that falls inside them.
    repeat (5) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    repeat (4) @(posedge bus_clk);
    @(negedge mclk);
    chk("oe after reset", 9'h0, {6'h00, ts_oe, sda_oe, scl_oe});
    chk("pin low level", 9'h0, {6'h00, scl_out, sda_out, ts_out});
    chk("idle pins", 9'h7, {6'h00, scl_w, sda_w, ts_w});
    fill_frame(3, 1'b1);
    fork
      m.host_read(7'h42, 3, ack);
      begin
        k = 0;
        while (host_reading !== 1'b1 && k < LIMIT) begin
          @(negedge mclk);
          k++;
        end
        give_up(k);
        chk("ts_oe in read", 9'h0, {8'h00, ts_oe});
        fill_frame(2, 1'b1);
      end
    join
    chk("read addr ack", 9'h0, {8'h00, ack});
    m.host_read(7'h42, 2, ack);
    chk("second read ack", 9'h0, {8'h00, ack});
    addr_select_pin = 1'b1;
    repeat (4) @(posedge bus_clk);
    m.start();
    m.send_byte(8'h86, ack);
    chk("write addr ack", 9'h0, {8'h00, ack});
    for (int i = 0; i < 2; i++) begin
      b = lfsr8;
      lfsr8 = lfsr_next(lfsr8);
      exp_cmd.push_back({i == 0, b});
      m.send_byte(b, ack);
      chk("write data ack", 9'h0, {8'h00, ack});
    end
    m.stop();
    m.start();
    m.send_byte(8'h84, ack);
    chk("foreign addr", 9'h1, {8'h00, ack});
    m.send_byte(8'h00, ack);
    chk("ignored byte", 9'h1, {8'h00, ack});
    m.stop();
    fill_frame(2, 1'b0);
    drops0 = drops;
    fill_frame(2, 1'b1);
    chk("periodic release", 9'h1, 9'(drops - drops0));
    m.host_read(7'h43, 2, ack);
    chk("pin one read ack", 9'h0, {8'h00, ack});
    repeat (50) @(posedge mclk);
    chk("pending notes", 9'h0, 9'(exp_cmd.size() + exp_rd.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
